// file: pgc_cfg.svh
`ifndef PGC_CFG_SVH
`define PGC_CFG_SVH

// channel and generator counts
`define PGC_NCH 8
`define PGC_NGEN 4
`define PGC_NPAIR 4

// register byte offsets
`define PGC_OFS_CTRL 8'h00
`define PGC_OFS_PRESC 8'h04
`define PGC_OFS_CLKSEL 8'h08
`define PGC_OFS_DEAD 8'h0c
`define PGC_OFS_PIEN 8'h10
`define PGC_OFS_PIND 8'h14
`define PGC_OFS_CCR0L 8'h18
`define PGC_OFS_CCR0H 8'h1c
`define PGC_OFS_CCR1L 8'h20
`define PGC_OFS_CCR1H 8'h24

// arrays of eight words, selected by address bits 7:5
`define PGC_BLK_PER 3'h2
`define PGC_BLK_CMP 3'h3
`define PGC_BLK_RLAT 3'h4
`define PGC_BLK_FLAT 3'h5
`define PGC_BLK_CNT 3'h6

// generator_control_reg field positions
`define PGC_CTRL_RUN 0
`define PGC_CTRL_AUTO 8
`define PGC_CTRL_PAIR 16

// capture control fields, per 16-bit half
`define PGC_CCR_CAPEN 0
`define PGC_CCR_IE_R 1
`define PGC_CCR_IE_F 2
`define PGC_CCR_FLAG_R 6
`define PGC_CCR_FLAG_F 7
`define PGC_CCR_HALF 16

// largest divider select code (1/16)
`define PGC_DIV_MAX 3'h4

// reset value of the whole state
`define PGC_RST_STATE '0

`endif

// file: pgc_pkg.sv
`include "pgc_cfg.svh"

package pgc_pkg;

  // whole state of the block, registered in one place
  typedef struct packed {
    logic [31:0] ctrl;
    logic [`PGC_NGEN-1:0][7:0] presc;
    logic [`PGC_NCH-1:0][2:0] clksel;
    logic [`PGC_NPAIR-1:0][7:0] dead;
    logic [`PGC_NCH-1:0] pien;
    logic [`PGC_NCH-1:0] pind;
    logic [3:0][31:0] ccr;
    logic [`PGC_NCH-1:0][15:0] per_buf;
    logic [`PGC_NCH-1:0][15:0] cmp_buf;
    logic [`PGC_NCH-1:0][15:0] cnt;
    logic [`PGC_NCH-1:0][15:0] cmp;
    logic [`PGC_NCH-1:0][15:0] rlat;
    logic [`PGC_NCH-1:0][15:0] flat;
    logic [`PGC_NCH-1:0] done;
    logic [`PGC_NCH-1:0] raw;
    logic [`PGC_NGEN-1:0][7:0] pcnt;
    logic [`PGC_NGEN-1:0][3:0] dvc;
    logic [`PGC_NPAIR-1:0][7:0] dzc;
    logic [`PGC_NPAIR-1:0] dprev;
    logic [`PGC_NCH-1:0] pout;
    logic [`PGC_NCH-1:0] poe;
    logic [`PGC_NCH-1:0] s1;
    logic [`PGC_NCH-1:0] s2;
    logic [`PGC_NCH-1:0] s3;
    logic ack;
    logic [31:0] dat;
    logic irq;
  } pgc_state_t;

endpackage

// file: pgc_top.sv
`timescale 1ns/10ps
`include "pgc_cfg.svh"

module pgc_top (
  input wire logic clk, // 50 MHz system clock
  input wire logic reset_n, // asynchronous reset, active low
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // single-cycle acknowledge
  input wire logic [`PGC_NCH-1:0] pwm_in, // pin levels for capture
  output logic [`PGC_NCH-1:0] pwm_out, // waveform outputs
  output logic [`PGC_NCH-1:0] pwm_oe, // pin drive enables
  output logic irq // interrupt request
);

  // registered state and its next value; every flop of the block
  // lives in r, so reset and clocking are handled in exactly one place
  // and no output can escape the single register stage
  // limitation: the whole struct resets together, there is no
  // partial or soft reset of one generator
  pgc_pkg::pgc_state_t r;
  pgc_pkg::pgc_state_t n;

  // combinational helpers, all rebuilt every cycle
  // sh and dm are shared scratch for the divider select of each channel
  // chg is scratch for the pair loop; neither holds state
  // cap_irq is per channel so one source can be masked without the rest
  logic hit;
  logic wr;
  logic [31:0] wmask;
  logic [31:0] rdata;
  logic [2:0] blk;
  logic [2:0] ix;
  logic [`PGC_NGEN-1:0] tick_g;
  logic [`PGC_NCH-1:0] tick;
  logic [`PGC_NCH-1:0] rise;
  logic [`PGC_NCH-1:0] fall;
  logic [`PGC_NCH-1:0] cap_en;
  logic [`PGC_NCH-1:0] cap_irq;
  logic [2:0] sh;
  logic [3:0] dm;
  logic chg;

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [31:0] m);
    merge = (old & ~m) | (d & m);
  endfunction

  // ccr word holding channel c: two words per group, two channels a word
  function automatic logic [1:0] ccr_word(input int c);
    ccr_word = 2'((c / 4) * 2 + (c % 4) / 2);
  endfunction

  // bit base of channel c inside its ccr word
  function automatic logic [4:0] ccr_base(input int c);
    ccr_base = 5'((c % 2) * `PGC_CCR_HALF);
  endfunction

  // a request held after its ack is not taken twice: hit needs ack low
  // the read mux uses the full byte address for the single words and
  // the upper three bits for the eight-word arrays
  // read data is registered with the ack, so the mux may settle late
  // trade-off: one cycle of latency on every access for clean timing
  // bus decode and read mux
  always_comb
  begin
    hit = wb_cyc_i & wb_stb_i & ~r.ack;
    wr = hit & wb_we_i;
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
             {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    blk = wb_adr_i[7:5];
    ix = wb_adr_i[4:2];
    rdata = 32'h0;
    case (wb_adr_i)
      `PGC_OFS_CTRL: rdata = r.ctrl;
      `PGC_OFS_PRESC: rdata = r.presc;
      `PGC_OFS_CLKSEL: rdata = {8'h00, r.clksel};
      `PGC_OFS_DEAD: rdata = r.dead;
      `PGC_OFS_PIEN: rdata = {24'h0, r.pien};
      `PGC_OFS_PIND: rdata = {24'h0, r.pind};
      `PGC_OFS_CCR0L: rdata = r.ccr[0];
      `PGC_OFS_CCR0H: rdata = r.ccr[1];
      `PGC_OFS_CCR1L: rdata = r.ccr[2];
      `PGC_OFS_CCR1H: rdata = r.ccr[3];
      default:
      begin
        // unmapped words read as zero
        case (blk)
          `PGC_BLK_PER: rdata = {16'h0, r.per_buf[ix]};
          `PGC_BLK_CMP: rdata = {16'h0, r.cmp_buf[ix]};
          `PGC_BLK_RLAT: rdata = {16'h0, r.rlat[ix]};
          `PGC_BLK_FLAT: rdata = {16'h0, r.flat[ix]};
          `PGC_BLK_CNT: rdata = {16'h0, r.cnt[ix]};
          default: rdata = 32'h0;
        endcase
      end
    endcase
  end

  // next-state logic for the whole block
  always_comb
  begin
    n = r;
    tick_g = '0;
    tick = '0;
    cap_en = '0;
    cap_irq = '0;
    sh = 3'h0;
    dm = 4'h0;
    chg = 1'b0;

    // bus answer: one ack per request, read data with it
    n.ack = hit;
    n.dat = (hit & ~wb_we_i) ? rdata : 32'h0;

    // hazard: a hardware set and a software clear in one cycle
    // the bus clear is applied first and the event later in this
    // process, so the event overrides and no interrupt is lost
    // a write of zero to a flag bit leaves it untouched
    // software writes; flag bits clear on one, bus first so sets win
    if (wr)
    begin
      case (wb_adr_i)
        `PGC_OFS_CTRL: n.ctrl = merge(r.ctrl, wb_dat_i, wmask);
        `PGC_OFS_PRESC: n.presc = merge(r.presc, wb_dat_i, wmask);
        `PGC_OFS_CLKSEL:
          n.clksel = 24'(merge({8'h00, r.clksel}, wb_dat_i, wmask));
        `PGC_OFS_DEAD: n.dead = merge(r.dead, wb_dat_i, wmask);
        `PGC_OFS_PIEN:
          n.pien = 8'(merge({24'h0, r.pien}, wb_dat_i, wmask));
        `PGC_OFS_PIND:
          n.pind = r.pind & ~(wb_dat_i[7:0] & wmask[7:0]);
        `PGC_OFS_CCR0L, `PGC_OFS_CCR0H, `PGC_OFS_CCR1L, `PGC_OFS_CCR1H:
        begin
          for (int h = 0; h < 2; h++)
          begin
            for (int b = 0; b < `PGC_CCR_HALF; b++)
            begin
              if (b == `PGC_CCR_FLAG_R || b == `PGC_CCR_FLAG_F)
              begin
                if (wb_dat_i[h*16+b] && wmask[h*16+b])
                  n.ccr[wb_adr_i[3:2] ^ 2'h2][h*16+b] = 1'b0;
              end
              else if (wmask[h*16+b])
                n.ccr[wb_adr_i[3:2] ^ 2'h2][h*16+b] = wb_dat_i[h*16+b];
            end
          end
        end
        default:
        begin
          // buffers only; active copies load while stopped, compare at zero, period at zero in auto mode or on a capture reload
          if (blk == `PGC_BLK_PER)
            n.per_buf[ix] = 16'(merge({16'h0, r.per_buf[ix]},
                                      wb_dat_i, wmask));
          else if (blk == `PGC_BLK_CMP)
            n.cmp_buf[ix] = 16'(merge({16'h0, r.cmp_buf[ix]},
                                      wb_dat_i, wmask));
        end
      endcase
    end

    // the divider counter runs free, so a new select takes effect at
    // once but the first tick after a change may come early
    // prescale zero gives a tick on every clock
    // both channels of a generator share prescaler and divider counter
    // prescaler divides by value plus one, then a free divider
    for (int g = 0; g < `PGC_NGEN; g++)
    begin
      tick_g[g] = (r.pcnt[g] == 8'h00);
      n.pcnt[g] = tick_g[g] ? r.presc[g] : r.pcnt[g] - 8'h01;
      if (tick_g[g])
        n.dvc[g] = r.dvc[g] + 4'h1;
    end

    // pins are asynchronous: two flops guard against metastability
    // and only the second flop feeds the edge flop and detectors
    // cost: an edge is seen three clocks after it reaches the pin
    // the chain resets low, matching a released idle pin
    // capture input edges from the synchronised pins
    n.s1 = pwm_in;
    n.s2 = r.s1;
    n.s3 = r.s2;
    rise = r.s2 & ~r.s3;
    fall = ~r.s2 & r.s3;

    // a stopped channel tracks its buffers, so starting it always
    // begins from the latest written period and compare values
    // a running channel loads compare at zero, and the period there with auto-reload; the period also on a
    // capture edge whose interrupt enable is set, even if it is half written
    // eight channel timers, two per generator
    for (int c = 0; c < `PGC_NCH; c++)
    begin
      // codes above 1/16 behave as 1/16
      sh = (r.clksel[c] > `PGC_DIV_MAX) ? `PGC_DIV_MAX : r.clksel[c];
      dm = ~(4'hf << sh);
      tick[c] = tick_g[c/2] & ((r.dvc[c/2] & dm) == 4'h0);
      cap_en[c] = r.ccr[ccr_word(c)][ccr_base(c) + `PGC_CCR_CAPEN];

      if (!r.ctrl[`PGC_CTRL_RUN + c])
      begin
        // stopped: active copies follow the buffers
        n.cnt[c] = r.per_buf[c];
        n.cmp[c] = r.cmp_buf[c];
        n.done[c] = 1'b0;
        n.raw[c] = 1'b0;
      end
      else if (tick[c] && !r.done[c])
      begin
        if (r.cnt[c] == 16'h0000)
        begin
          n.pind[c] = 1'b1;
          n.raw[c] = 1'b0;
          n.cmp[c] = r.cmp_buf[c];
          if (r.ctrl[`PGC_CTRL_AUTO + c])
            n.cnt[c] = r.per_buf[c];
          else
            n.done[c] = 1'b1;
        end
        else
        begin
          n.cnt[c] = r.cnt[c] - 16'h0001;
          if (r.cnt[c] == r.cmp[c])
            n.raw[c] = 1'b1;
        end
      end

      // capture takes priority over the timer for the counter reload,
      // since it comes later in this process
      // flags set on every edge; the enables gate only irq and reload
      // limitation: a second edge before service overwrites the latch
      // capture: latch live counter on edges, reload on interrupt
      if (cap_en[c])
      begin
        if (rise[c])
        begin
          n.rlat[c] = r.cnt[c];
          n.ccr[ccr_word(c)][ccr_base(c) + `PGC_CCR_FLAG_R] = 1'b1;
          if (r.ccr[ccr_word(c)][ccr_base(c) + `PGC_CCR_IE_R])
            n.cnt[c] = r.per_buf[c];
        end
        if (fall[c])
        begin
          n.flat[c] = r.cnt[c];
          n.ccr[ccr_word(c)][ccr_base(c) + `PGC_CCR_FLAG_F] = 1'b1;
          if (r.ccr[ccr_word(c)][ccr_base(c) + `PGC_CCR_IE_F])
            n.cnt[c] = r.per_buf[c];
        end
      end

      // capture interrupt only where its own enable is set
      cap_irq[c] =
        (n.ccr[ccr_word(c)][ccr_base(c) + `PGC_CCR_FLAG_R] &
         n.ccr[ccr_word(c)][ccr_base(c) + `PGC_CCR_IE_R]) |
        (n.ccr[ccr_word(c)][ccr_base(c) + `PGC_CCR_FLAG_F] &
         n.ccr[ccr_word(c)][ccr_base(c) + `PGC_CCR_IE_F]);

      // a capture channel releases its pin
      n.poe[c] = ~cap_en[c];
    end

    // the odd pin is built from the even raw level, never from its own
    // timer, so the two can not drift apart in paired mode
    // a change during a running dead time restarts it, which keeps
    // both pins low through short pulses rather than overlapping them
    // pairs: dead time counts in system clocks, any change restarts it
    for (int p = 0; p < `PGC_NPAIR; p++)
    begin
      chg = r.raw[2*p] != r.dprev[p];
      n.dprev[p] = r.raw[2*p];
      if (chg)
        n.dzc[p] = r.dead[p];
      else if (r.dzc[p] != 8'h00)
        n.dzc[p] = r.dzc[p] - 8'h01;
      if (r.ctrl[`PGC_CTRL_PAIR + p])
      begin
        // both low while the dead time runs, so never both high
        n.pout[2*p] = r.raw[2*p] & ~chg & (r.dzc[p] == 8'h00);
        n.pout[2*p+1] = ~r.raw[2*p] & ~chg &
                        (r.dzc[p] == 8'h00);
      end
      else
      begin
        n.pout[2*p] = r.raw[2*p];
        n.pout[2*p+1] = r.raw[2*p+1];
      end
    end
    // a pin in capture mode drives nothing
    n.pout = n.pout & ~cap_en;

    // one request line, gated per source
    n.irq = (|(n.pind & n.pien)) | (|cap_irq);
  end

  // asynchronous reset puts every field, outputs included, to zero
  // so pins are released and no request is raised while in reset
  // only constants are loaded in the reset branch
  // drive enables come up one clock after release
  // the one register of the block
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      r <= `PGC_RST_STATE;
    else
      r <= n;
  end

  // no logic sits between the register and any output pin
  // so every output is glitch free and sees one clock of delay
  // read data is zero outside its ack cycle
  // pwm_out is zero on any channel in capture mode
  // outputs straight from flip-flops
  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack;
  assign pwm_out = r.pout;
  assign pwm_oe = r.poe;
  assign irq = r.irq;

endmodule

// file: pgc_asserts.sv
`timescale 1ns/10ps
`include "pgc_cfg.svh"
module pgc_asserts (
  input wire logic clk, // clock
  input wire logic reset_n, // reset, low
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [7:0] wb_adr_i, // address
  input wire logic [3:0] wb_sel_i, // lanes
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // ack
  input wire logic [`PGC_NCH-1:0] pwm_in, // pins
  input wire logic [`PGC_NCH-1:0] pwm_out, // outputs
  input wire logic [`PGC_NCH-1:0] pwm_oe, // enables
  input wire logic irq // interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [3:0] pair_m;
  logic [7:0] pien_m;
  logic cie_m;
  logic wr_t;
  assign wr_t = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  // bus shadows; cie is sticky, so the gate check errs on the safe side
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pair_m <= 4'h0;
      pien_m <= 8'h00;
      cie_m <= 1'b0;
    end
    else if (wr_t)
    begin
      if (wb_adr_i[7:2] == 6'h00 && wb_sel_i[2])
        pair_m <= wb_dat_i[19:16];
      if (wb_adr_i[7:2] == 6'h04 && wb_sel_i[0])
        pien_m <= wb_dat_i[7:0];
      if (wb_adr_i[7:2] >= 6'h06 && wb_adr_i[7:2] <= 6'h09
          && |(wb_dat_i & 32'h00060006))
        cie_m <= 1'b1;
    end
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_req: assert property (s_req |=> s_ans)
    else $error("ack missing or too long");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
    else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_out_capture: assert property (
    (pwm_out & ~pwm_oe & ~$past(pwm_oe) & ~$past(pwm_oe, 2)) == 8'h00)
    else $error("capture pin driven high");
  a_irq_gate: assert property (
    irq |-> (pien_m | $past(pien_m)) != 8'h00 || cie_m)
    else $error("irq without enable");
  for (genvar p = 0; p < 4; p++)
  begin : g_pair
    a_pair_excl: assert property (
      pair_m[p] && $past(pair_m[p], 4)
      |-> !(pwm_out[2*p] && pwm_out[2*p+1]))
      else $error("pair both high");
    a_even_dead: assert property (
      $rose(pwm_out[2*p]) && pair_m[p] && $past(pair_m[p], 4)
      |-> !$past(pwm_out[2*p+1]))
      else $error("even rise without dead time");
    a_odd_dead: assert property (
      $rose(pwm_out[2*p+1]) && pair_m[p] && $past(pair_m[p], 4)
      |-> !$past(pwm_out[2*p]))
      else $error("odd rise without dead time");
  end
endmodule

// file: pgc_pin_model.sv
`timescale 1ns/10ps
module pgc_pin_model (
  input wire logic [7:0] src, // source levels
  input wire logic [7:0] pwm_out, // block outputs
  input wire logic [7:0] pwm_oe, // block enables
  output logic [7:0] pin // pin levels
);
  // driven pins follow the block, released ones the source
  assign pin = (pwm_oe & pwm_out) | (~pwm_oe & src);
endmodule

// file: pgc_top_bench.sv
`timescale 1ns/10ps
`include "pgc_cfg.svh"
module pgc_top_bench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00, src = 8'h00, pin, pout, poe;
  logic [3:0] sel = 4'h0;
  logic [31:0] dwr = 32'h0, drd, q;
  logic ack, irq, hi0 = 1'b0, hi1 = 1'b0;
  int err_count = 0, checked = 0, n;
  pgc_top i_dut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dwr), .wb_dat_o(drd), .wb_ack_o(ack), .pwm_in(pin),
    .pwm_out(pout), .pwm_oe(poe), .irq(irq));
  pgc_pin_model i_pin (.src(src), .pwm_out(pout), .pwm_oe(poe),
    .pin(pin));
  initial
    forever #10 clk = ~clk;
  // sticky marks of outputs seen high
  always @(posedge clk)
  begin
    if (pout[0] === 1'b1)
      hi0 <= 1'b1;
    if (pout[1] === 1'b1)
      hi1 <= 1'b1;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, v);
    checked++;
    if (v !== e)
    begin
      err_count++;
      $display("wrong value %s exp %h got %h", nm, e, v);
    end
  endtask
  // one classic cycle; holds all until ack, then one idle cycle
  task automatic wbx(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dwr <= d;
    sel <= 4'hf;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      err_count++;
      finish_test();
    end
    q = drd;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wbx(1'b1, a, d);
  endtask
  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    wbx(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  // bounded wait for the request, cycles counted in n
  task automatic wirq();
    n = 0;
    while (irq !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000)
    begin
      err_count++;
      finish_test();
    end
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    wr(8'hfc, 32'hffffffff);
    rd("unmap", 8'hfc, 32'h0);
    // one-shot on channel 0
    wr(8'h40, 32'h5);
    wr(8'h60, 32'h2);
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h1);
    wirq();
    chk("out0", 32'h1, hi0);
    rd("pind", 8'h14, 32'h1);
    rd("cnt0", 8'hc0, 32'h0);
    wr(8'h14, 32'h0);
    rd("keep", 8'h14, 32'h1);
    wr(8'h10, 32'h0);
    chk("mask", 32'h0, irq);
    wr(8'h14, 32'h1);
    rd("clr", 8'h14, 32'h0);
    repeat (20) @(posedge clk);
    rd("once", 8'h14, 32'h0);
    // auto-reload on channel 1, new period taken at zero
    wr(8'h00, 32'h0);
    wr(8'h44, 32'h3);
    wr(8'h10, 32'h2);
    wr(8'h00, 32'h202);
    wirq();
    wr(8'h44, 32'h20);
    wr(8'h14, 32'h2);
    wirq();
    wbx(1'b0, 8'hc4, 32'h0);
    chk("reld", 32'h1, q > 3 && q <= 32);
    // divide by 16 on channel 2
    wr(8'h00, 32'h0);
    wr(8'h14, 32'hff);
    wr(8'h08, 32'h100);
    wr(8'h48, 32'h2);
    wr(8'h10, 32'h4);
    wr(8'h00, 32'h4);
    wirq();
    chk("div", 32'h1, n >= 16 && n <= 64);
    // pair 01 from timer 0 with dead time 3
    wr(8'h00, 32'h0);
    wr(8'h10, 32'h0);
    wr(8'h0c, 32'h3);
    wr(8'h40, 32'h8);
    wr(8'h60, 32'h4);
    wr(8'h00, 32'h10101);
    repeat (100) @(posedge clk);
    chk("odd", 32'h1, hi1);
    // capture on channel 0
    wr(8'h00, 32'h0);
    wr(8'h40, 32'h100);
    wr(8'h00, 32'h101);
    wr(8'h18, 32'h3);
    chk("oe0", 32'h0, poe[0]);
    src <= 8'h01;
    wirq();
    wbx(1'b0, 8'hc0, 32'h0);
    chk("cnt", 32'h1, q >= 32'hf0);
    rd("rflg", 8'h18, 32'h43);
    wbx(1'b0, 8'h80, 32'h0);
    chk("rlat", 32'h1, q > 0 && q <= 32'h100);
    wr(8'h18, 32'h43);
    rd("rclr", 8'h18, 32'h3);
    src <= 8'h00;
    repeat (10) @(posedge clk);
    chk("nfirq", 32'h0, irq);
    rd("fflg", 8'h18, 32'h83);
    finish_test();
  end
endmodule
bind pgc_top pgc_asserts i_chk (.clk(clk), .reset_n(reset_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pwm_in(pwm_in),
  .pwm_out(pwm_out), .pwm_oe(pwm_oe), .irq(irq));
